// ==== hdl/pds_ctrl.sv ====
// packet dma switch control: ahb registers, irq, tx scheduler, rx steering
`timescale 1ns/1ps
`default_nettype none
module pds_ctrl
   import pds_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire pds_evt_s evt,
   output logic irq,
   input wire logic [3:0] tx_queue_req,
   input wire logic [3:0] tx_ring_pause,
   input wire logic tx_grant_ready,
   output logic tx_grant_valid,
   output logic [3:0] tx_grant,
   input wire pds_rx_frame_s rx_frame,
   output pds_rx_dec_s rx_dec,
   input wire logic [11:0] rx_free_cnt0,
   input wire logic [11:0] rx_free_cnt1,
   output logic [1:0] rx_ring_stall,
   output logic [3:0] switch_queue_pause,
   output logic loopback_en
);
   // ***************************************************************
   // state and helpers
   // ***************************************************************
   pds_state_s st;
   pds_state_s next_st;
   logic [3:0] req_eff;
   logic [1:0] pick;
   logic use_wrr;
   logic [2:0] cur_wt;
   logic acc;
   logic [31:0] clr;
   logic [31:0] set;
   logic map_bit;

   // round robin: stay on the current queue for weight+1 grants
   function automatic logic [1:0] wrr_pick(
      input logic [3:0] e,
      input logic [1:0] cur,
      input logic [3:0] used,
      input logic [2:0] w
   );
      logic [1:0] idx;
      wrr_pick = cur;
      if (!(e[cur] && used <= {1'b0, w})) begin
         // walk downward so the nearest successor wins
         for (int i = 4; i >= 1; i--) begin
            idx = cur + 2'(i);
            if (e[idx]) begin
               wrr_pick = idx;
            end
         end
      end
   endfunction

   // register read mux; unmapped words read zero
   function automatic logic [31:0] rd_word(input pds_state_s s);
      case (s.addr)
         ADDR_FREEQ: rd_word = {28'h000_0000, s.freeq};
         ADDR_STAT: rd_word = s.irq_status;
         ADDR_MASK: rd_word = s.irq_mask;
         ADDR_SCHED: rd_word = s.sched;
         ADDR_WT: rd_word = s.weights;
         ADDR_CON: rd_word = s.con;
         ADDR_STEER: rd_word = s.steer;
         default: rd_word = 32'h0000_0000;
      endcase
   endfunction

   // ***************************************************************
   // transmit scheduler
   // ***************************************************************
   // queues paused by the switch drop out only when pausing is on
   assign req_eff = tx_queue_req & ~(st.con[CON_FC] ? tx_ring_pause : 4'h0);
   assign cur_wt = st.weights[WT_STRIDE * st.wrr_cur +: 3];

   // pick the queue to serve from the scheduling policy
   always_comb begin
      use_wrr = 1'b0;
      pick = 2'h0;
      case (pds_sched_e'(st.sched[SCHED_LSB +: 2]))
         SCH_WRR: begin
            use_wrr = 1'b1;
            pick = wrr_pick(req_eff, st.wrr_cur, st.wrr_used, cur_wt);
         end
         SCH_STRICT: begin
            if (req_eff[3]) begin
               pick = 2'h3;
            end else if (req_eff[2]) begin
               pick = 2'h2;
            end else if (req_eff[1]) begin
               pick = 2'h1;
            end else begin
               pick = 2'h0;
            end
         end
         SCH_Q3_WRR: begin
            if (req_eff[3]) begin
               pick = 2'h3;
            end else begin
               use_wrr = 1'b1;
               pick = wrr_pick(req_eff & 4'h7, st.wrr_cur, st.wrr_used, cur_wt);
            end
         end
         SCH_Q3_Q2_WRR: begin
            if (req_eff[3]) begin
               pick = 2'h3;
            end else if (req_eff[2]) begin
               pick = 2'h2;
            end else begin
               use_wrr = 1'b1;
               pick = wrr_pick(req_eff & 4'h3, st.wrr_cur, st.wrr_used, cur_wt);
            end
         end
         default: begin
            use_wrr = 1'b0;
            pick = 2'h0;
         end
      endcase
   end

   // grant is a handshake, combinational from state and requests
   assign tx_grant_valid = |req_eff;
   assign tx_grant = tx_grant_valid ? (4'h1 << pick) : 4'h0;

   // ***************************************************************
   // next state
   // ***************************************************************
   assign acc = hsel & htrans[1] & hready;

   always_comb begin
      next_st = st;
      clr = 32'h0000_0000;
      set = 32'h0000_0000;
      map_bit = 1'b0;
      // bus phases; reads take one wait state to register hrdata
      if (st.ph == PH_RWAIT) begin
         next_st.ph = PH_RDATA;
         next_st.rdata = rd_word(st);
      end else if (acc) begin
         next_st.addr = haddr;
         if (!hwrite) begin
            next_st.ph = PH_RWAIT;
         end else if (hsize == HSIZE_WORD) begin
            next_st.ph = PH_WRITE;
         end else begin
            next_st.ph = PH_IDLE;
         end
      end else begin
         next_st.ph = PH_IDLE;
      end
      // word writes land at the end of the data phase, masked; other sizes are dropped
      if (st.ph == PH_WRITE) begin
         case (st.addr)
            ADDR_FREEQ: next_st.freeq = hwdata[3:0] & MASK_FREEQ;
            ADDR_STAT: clr = hwdata & MASK_IRQ;
            ADDR_MASK: next_st.irq_mask = hwdata & MASK_IRQ;
            ADDR_SCHED: next_st.sched = hwdata & MASK_SCHED;
            ADDR_WT: next_st.weights = hwdata & MASK_WT;
            ADDR_CON: next_st.con = hwdata & MASK_CON;
            ADDR_STEER: next_st.steer = hwdata & MASK_STEER;
            default: clr = 32'h0000_0000;
         endcase
      end
      // event capture; a set in the clearing cycle wins
      set[ST_TX_DONE +: 4] = evt.tx_done;
      set[ST_RX_DONE +: 2] = evt.rx_done;
      set[ST_TX_COH] = evt.tx_coherent;
      set[ST_RX_COH] = evt.rx_coherent;
      set[ST_RX_DLY] = |evt.rx_done | evt.rx_coherent;
      set[ST_TX_DLY] = |evt.tx_done | evt.tx_coherent;
      next_st.irq_status = (st.irq_status & ~clr) | set;
      // irq follows the gated status one cycle later
      next_st.irq = |(st.irq_status & st.irq_mask);
      // round robin bookkeeping on each accepted wrr grant
      if (tx_grant_valid && tx_grant_ready && use_wrr) begin
         if (pick == st.wrr_cur && st.wrr_used <= {1'b0, cur_wt}) begin
            next_st.wrr_used = st.wrr_used + 4'h1;
         end else begin
            next_st.wrr_cur = pick;
            next_st.wrr_used = 4'h1;
         end
      end
      // receive decision, one cycle after the frame header
      next_st.dec.valid = rx_frame.valid;
      if (rx_frame.valid) begin
         if (st.con[CON_PORTMAP]) begin
            // ports above four fall to ring 1
            if (rx_frame.port <= MAX_PORT) begin
               map_bit = st.steer[STEER_PORT_LSB + int'(rx_frame.port)];
            end
         end else begin
            map_bit = st.steer[rx_frame.prio];
         end
         next_st.dec.ring = ~map_bit;
         next_st.dec.drop = (rx_frame.addr_unknown & st.con[CON_UNDROP])
            | (|(rx_frame.sum_err & st.con[CON_SUM_LSB +: 3]));
         next_st.dec.sum_report = rx_frame.sum_err & ~st.con[CON_SUM_LSB +: 3];
         next_st.dec.special_tag = st.con[CON_SHORTTAG] && rx_frame.tag[15:8] == TAG_FIRST;
         next_st.dec.outer_vlan = rx_frame.tag == st.con[15:0];
         next_st.dec.inner_vlan = rx_frame.tag == VLAN_INNER;
      end
      // ring stalls once free descriptors fall to the threshold
      next_st.stall[0] = rx_free_cnt0 <= {8'h00, st.freeq};
      next_st.stall[1] = rx_free_cnt1 <= {8'h00, st.freeq};
      // each switch queue watches the ring it was given
      for (int q = 0; q < 4; q++) begin
         next_st.qpause[q] = st.steer[STEER_QP_LSB + q] ? st.stall[0] : st.stall[1];
      end
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   // all state, reset to constants only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
         st.con <= RST_CON;
         st.freeq <= RST_FREEQ;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from state
   assign hreadyout = st.ph != PH_RWAIT;
   assign hresp = 1'b0;
   assign hrdata = st.rdata;
   assign irq = st.irq;
   assign rx_dec = st.dec;
   assign rx_ring_stall = st.stall;
   assign switch_queue_pause = st.qpause;
   assign loopback_en = st.con[CON_LOOP];

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_rd_wait;
      acc && !hwrite |=> s_rd_answer;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read answer timing wrong");

   property p_irq_on;
      (|(st.irq_status & st.irq_mask)) |=> irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq not raised");

   property p_irq_off;
      !(|(st.irq_status & st.irq_mask)) |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq without enabled source");

   property p_tx_coh;
      evt.tx_coherent |=> st.irq_status[ST_TX_COH];
   endproperty
   a_tx_coh: assert property (p_tx_coh) else $error("tx coherence lost");

   property p_rx_coh;
      evt.rx_coherent |=> st.irq_status[ST_RX_COH] && st.irq_status[ST_RX_DLY];
   endproperty
   a_rx_coh: assert property (p_rx_coh) else $error("rx coherence lost");

   property p_rx_done;
      evt.rx_done[1] |=> st.irq_status[ST_RX_DONE + 1];
   endproperty
   a_rx_done: assert property (p_rx_done) else $error("rx ring 1 done lost");

   property p_tx_sum;
      evt.tx_done[3] |=> st.irq_status[ST_TX_DONE + 3] && st.irq_status[ST_TX_DLY];
   endproperty
   a_tx_sum: assert property (p_tx_sum) else $error("tx done or summary lost");

   property p_strict;
      st.sched[SCHED_LSB +: 2] == 2'h1 && req_eff[3] |-> tx_grant == 4'h8;
   endproperty
   a_strict: assert property (p_strict) else $error("strict mode skipped queue 3");

   property p_mixed;
      st.sched[SCHED_LSB +: 2] == 2'h3 && !req_eff[3] && req_eff[2] |-> tx_grant == 4'h4;
   endproperty
   a_mixed: assert property (p_mixed) else $error("mixed mode skipped queue 2");

   property p_fc;
      st.con[CON_FC] |-> (tx_grant & tx_ring_pause) == 4'h0;
   endproperty
   a_fc: assert property (p_fc) else $error("paused queue granted");

   property p_ring;
      rx_frame.valid && !st.con[CON_PORTMAP] && st.ph != PH_WRITE
         |=> rx_dec.valid && rx_dec.ring == !st.steer[$past(rx_frame.prio)];
   endproperty
   a_ring: assert property (p_ring) else $error("priority ring wrong");

   property p_drop;
      rx_frame.valid && rx_frame.sum_err[2] && st.con[CON_SUM_LSB + 2] |=> rx_dec.drop;
   endproperty
   a_drop: assert property (p_drop) else $error("udp error not dropped");

   property p_stall;
      rx_free_cnt0 <= {8'h00, st.freeq} |=> rx_ring_stall[0];
   endproperty
   a_stall: assert property (p_stall) else $error("ring 0 not stalled");

   // one decision pulse per frame header, none without one
   property p_dec_pulse;
      rx_frame.valid |=> rx_dec.valid;
   endproperty
   a_dec_pulse: assert property (p_dec_pulse) else $error("rx decision missing");

   property p_dec_quiet;
      !rx_frame.valid |=> !rx_dec.valid;
   endproperty
   a_dec_quiet: assert property (p_dec_quiet) else $error("rx decision without frame");

   property p_port_high;
      rx_frame.valid && st.con[CON_PORTMAP] && rx_frame.port > MAX_PORT |=> rx_dec.ring;
   endproperty
   a_port_high: assert property (p_port_high) else $error("unmapped port not sent to ring 1");

   property p_unknown;
      rx_frame.valid && rx_frame.addr_unknown && st.con[CON_UNDROP] |=> rx_dec.drop;
   endproperty
   a_unknown: assert property (p_unknown) else $error("unknown address frame kept");

   property p_inner;
      rx_frame.valid && rx_frame.tag == VLAN_INNER |=> rx_dec.inner_vlan;
   endproperty
   a_inner: assert property (p_inner) else $error("inner vlan tag missed");

   property p_short_off;
      rx_frame.valid && !st.con[CON_SHORTTAG] |=> !rx_dec.special_tag;
   endproperty
   a_short_off: assert property (p_short_off) else $error("special tag seen while disabled");

   property p_qpause;
      st.steer[STEER_QP_LSB] && rx_ring_stall[0] |=> switch_queue_pause[0];
   endproperty
   a_qpause: assert property (p_qpause) else $error("queue 0 not paused by ring 0");

   property p_tx_done0;
      evt.tx_done[0] |=> st.irq_status[ST_TX_DONE] && st.irq_status[ST_TX_DLY];
   endproperty
   a_tx_done0: assert property (p_tx_done0) else $error("tx ring 0 done lost");
endmodule
`default_nettype wire

// ==== shared/pds_pkg.sv ====
// shared constants and types of the packet dma switch control block
package pds_pkg;
   // ***************************************************************
   // register byte addresses
   // ***************************************************************
   localparam logic [31:0] ADDR_FREEQ = 32'h1010_0a10;
   localparam logic [31:0] ADDR_STAT = 32'h1010_0a20;
   localparam logic [31:0] ADDR_MASK = 32'h1010_0a28;
   localparam logic [31:0] ADDR_SCHED = 32'h1010_0a80;
   localparam logic [31:0] ADDR_WT = 32'h1010_0a84;
   localparam logic [31:0] ADDR_CON = 32'h1010_0c00;
   localparam logic [31:0] ADDR_STEER = 32'h1010_0c04;
   // writable bits; the rest read zero
   localparam logic [31:0] MASK_IRQ = 32'hf003_000f;
   localparam logic [31:0] MASK_SCHED = 32'h0300_0000;
   localparam logic [31:0] MASK_WT = 32'h0000_7777;
   localparam logic [31:0] MASK_CON = 32'h00ff_ffff;
   localparam logic [31:0] MASK_STEER = 32'h000f_1fff;
   localparam logic [3:0] MASK_FREEQ = 4'hf;
   // reset values
   localparam logic [31:0] RST_CON = 32'h0007_8100;
   localparam logic [3:0] RST_FREEQ = 4'h2;
   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int ST_TX_DONE = 0;
   localparam int ST_RX_DONE = 16;
   localparam int ST_TX_DLY = 28;
   localparam int ST_TX_COH = 29;
   localparam int ST_RX_DLY = 30;
   localparam int ST_RX_COH = 31;
   localparam int SCHED_LSB = 24;
   localparam int WT_STRIDE = 4;
   localparam int CON_SUM_LSB = 16;
   localparam int CON_UNDROP = 19;
   localparam int CON_SHORTTAG = 20;
   localparam int CON_LOOP = 21;
   localparam int CON_PORTMAP = 22;
   localparam int CON_FC = 23;
   localparam int STEER_PORT_LSB = 8;
   localparam int STEER_QP_LSB = 16;
   localparam logic [2:0] MAX_PORT = 3'h4;
   localparam logic [7:0] TAG_FIRST = 8'h81;
   localparam logic [15:0] VLAN_INNER = 16'h8100;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {SCH_WRR, SCH_STRICT, SCH_Q3_WRR, SCH_Q3_Q2_WRR} pds_sched_e;
   typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_RWAIT, PH_RDATA} pds_phase_e;
   typedef struct packed {
      logic [3:0] tx_done;
      logic [1:0] rx_done;
      logic tx_coherent;
      logic rx_coherent;
   } pds_evt_s;
   // sum_err order is udp, tcp, ip header
   typedef struct packed {
      logic valid;
      logic [2:0] prio;
      logic [2:0] port;
      logic [15:0] tag;
      logic addr_unknown;
      logic [2:0] sum_err;
   } pds_rx_frame_s;
   typedef struct packed {
      logic valid;
      logic ring;
      logic drop;
      logic [2:0] sum_report;
      logic special_tag;
      logic outer_vlan;
      logic inner_vlan;
   } pds_rx_dec_s;
   typedef struct packed {
      pds_phase_e ph;
      logic [31:0] addr;
      logic [31:0] rdata;
      logic [31:0] irq_mask;
      logic [31:0] irq_status;
      logic [31:0] sched;
      logic [31:0] weights;
      logic [31:0] con;
      logic [31:0] steer;
      logic [3:0] freeq;
      logic [1:0] wrr_cur;
      logic [3:0] wrr_used;
      pds_rx_dec_s dec;
      logic [1:0] stall;
      logic [3:0] qpause;
      logic irq;
   } pds_state_s;
endpackage

// ==== sim/pds_far_end.sv ====
// far-end model: switch side that accepts transmit grants
`timescale 1ns/1ps
`default_nettype none
module pds_far_end (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic slow,
   output logic tx_grant_ready
);
   logic [1:0] ph;
   // slow mode takes one grant in three, so grants must stand while refused
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph <= 2'h0;
         tx_grant_ready <= 1'b0;
      end else begin
         ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
         tx_grant_ready <= !slow || (ph == 2'h2);
      end
   end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench of the packet dma switch control block
`timescale 1ns/1ps
`default_nettype none
module tb
   import pds_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, slow, tx_grant_ready;
   logic tx_grant_valid, loopback_en, fc, rec;
   logic [31:0] haddr, hwdata, hrdata, seed, rd, d, p, s, t, con, steer, wt;
   logic [1:0] htrans, rx_ring_stall, m, sx;
   logic [2:0] hsize;
   logic [3:0] tx_queue_req, tx_ring_pause, tx_grant, switch_queue_pause, eff, set, win, pq;
   logic [11:0] rx_free_cnt0, rx_free_cnt1, c0, c1;
   pds_evt_s evt;
   pds_rx_frame_s rx_frame, fr;
   pds_rx_dec_s rx_dec, ed;
   int n_fail, tests_run, len, runs;
   logic [3:0] gq[$];
   logic [31:0] ra[6] = '{ADDR_MASK, ADDR_SCHED, ADDR_WT, ADDR_CON, ADDR_STEER, ADDR_FREEQ};
   logic [31:0] rm[6] = '{MASK_IRQ, MASK_SCHED, MASK_WT, MASK_CON, MASK_STEER, 32'h0000_000f};
   logic [31:0] rr[6] = '{32'h0, 32'h0, 32'h0, RST_CON, 32'h0, 32'h0000_0002};
   assign hready = hreadyout;
   pds_ctrl i_pds_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .evt(evt), .irq(irq), .tx_queue_req(tx_queue_req),
      .tx_ring_pause(tx_ring_pause), .tx_grant_ready(tx_grant_ready), .tx_grant_valid(tx_grant_valid),
      .tx_grant(tx_grant), .rx_frame(rx_frame), .rx_dec(rx_dec), .rx_free_cnt0(rx_free_cnt0),
      .rx_free_cnt1(rx_free_cnt1), .rx_ring_stall(rx_ring_stall), .switch_queue_pause(switch_queue_pause),
      .loopback_en(loopback_en));
   pds_far_end i_pds_far_end (.hclk(hclk), .hresetn(hresetn), .slow(slow), .tx_grant_ready(tx_grant_ready));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      for (int k = 0; k < 32; k++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // next requesting queue, cyclic upward
   function automatic logic [3:0] nxt(input logic [3:0] st, oh);
      logic [3:0] r;
      r = oh;
      for (int k = 0; k < 4; k++) begin
         r = {r[2:0], r[3]};
         if ((r & st) != 4'h0) return r;
      end
      return r;
   endfunction
   function automatic logic [1:0] ix(input logic [3:0] oh);
      return {oh[3] | oh[2], oh[3] | oh[1]};
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wait_rdy();
      @(negedge hclk);
      while (hreadyout !== 1'b1) @(negedge hclk);
      rd = hrdata;
      @(posedge hclk);
   endtask
   // one single transfer, a word unless sz says otherwise; the master waits on hready, never on a count
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] dv, input logic [2:0] sz = HSIZE_WORD);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= dv;
      wait_rdy();
   endtask
   task close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ****************************************
   // clock, watchdog, grant monitor
   // ****************************************
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // whole run needs under 2k cycles; 50k means a hang
   initial begin
      #500_000;
      n_fail++;
      close_out();
   end
   // sampled mid-cycle, where grant and ready have settled
   always @(negedge hclk) begin
      if (rec && tx_grant_valid === 1'b1 && tx_grant_ready === 1'b1) gq.push_back(tx_grant);
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {hsel, htrans, haddr, hwrite, hwdata, evt, tx_queue_req, tx_ring_pause, rx_frame} = '0;
      {hresetn, slow, rec, n_fail, tests_run} = '0;
      hsize = HSIZE_WORD;
      rx_free_cnt0 = 12'hfff;
      rx_free_cnt1 = 12'hfff;
      seed = 32'hef59_bcd6;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         ahb(0, ra[i], 32'h0);
         chk(rd, rr[i]);
         d = rnd();
         ahb(1, ra[i], d);
         ahb(0, ra[i], 32'h0);
         chk(rd, d & rm[i]);
      end
      ahb(1, ADDR_STAT + 32'h0000_0010, 32'hffff_ffff);
      ahb(0, ADDR_STAT + 32'h0000_0010, 32'h0);
      chk(rd, 32'h0);
      ahb(1, ADDR_CON, RST_CON);
      ahb(1, ADDR_CON, 32'h0, 3'h0);
      ahb(0, ADDR_CON, 32'h0);
      chk(rd, RST_CON);
      chk(hresp, 1'b0);
      $display("test registers done");
      // each event source: status, summary, enable, clear
      for (int i = 0; i < 8; i++) begin
         p = (i >= 4) ? 32'h1 << (i - 4) : (i >= 2) ? 32'h1 << (14 + i) : 32'h1 << (31 - 2 * i);
         s = (i == 1 || i >= 4) ? 32'h1000_0000 : 32'h4000_0000;
         ahb(1, ADDR_MASK, 32'h0);
         evt <= pds_evt_s'(8'h1 << i);
         @(posedge hclk);
         evt <= '0;
         ahb(0, ADDR_STAT, 32'h0);
         chk(rd, p | s);
         @(negedge hclk);
         chk(irq, 1'b0);
         ahb(1, ADDR_MASK, i[0] ? p : s);
         repeat (2) @(negedge hclk);
         chk(irq, 1'b1);
         ahb(1, ADDR_STAT, p | s);
         repeat (2) @(negedge hclk);
         chk(irq, 1'b0);
      end
      $display("test events done");
      // every mode twice, flow control on in modes 1 and 3 only, far side slow in modes 2 and 3
      for (int ph = 0; ph < 8; ph++) begin
         m = ph[1:0];
         fc = m[0];
         wt = rnd() & MASK_WT;
         t = rnd();
         ahb(1, ADDR_SCHED, {6'h0, m, 24'h0});
         ahb(1, ADDR_WT, wt);
         ahb(1, ADDR_CON, RST_CON | {8'h0, fc, 23'h0});
         tx_queue_req <= (ph < 4 || !m[1]) ? 4'hf : (m == 2'h2) ? 4'h7 : 4'h3;
         // mode 3 with queue 3 paused, so on the first pass queue 2 must win over the wrr pair
         tx_ring_pause <= (ph < 4 && m != 2'h3) ? t[3:0] & 4'h7 : 4'h8;
         slow <= m[1];
         gq.delete();
         rec = 1'b1;
         for (int k = 0; k < 900 && gq.size() < 60; k++) @(posedge hclk);
         rec = 1'b0;
         eff = tx_queue_req & ~(fc ? tx_ring_pause : 4'h0);
         win = 4'h0;
         if (m == 2'h1 || (m != 2'h0 && eff[3])) win = eff[3] ? 4'h8 : eff[2] ? 4'h4 : eff[1] ? 4'h2 : 4'h1;
         else if (m == 2'h3 && eff[2]) win = 4'h4;
         set = (m == 2'h0) ? eff : (m == 2'h2) ? eff & 4'h7 : eff & 4'h3;
         chk(gq.size(), 60);
         runs = 0;
         len = 0;
         foreach (gq[k]) begin
            if (win != 4'h0) begin
               chk(gq[k], win);
            end else if (k == 0) begin
               chk(gq[k] & set, gq[k]);
               len = 1;
            end else if (gq[k] == gq[k-1]) begin
               len++;
            end else begin
               if (runs > 0) chk(len, wt[4*ix(gq[k-1]) +: 3] + 1);
               chk(gq[k], nxt(set, gq[k-1]));
               runs++;
               len = 1;
            end
         end
      end
      $display("test scheduler done");
      // receive decisions under random control and steering words
      for (int c = 0; c < 4; c++) begin
         con = rnd() & MASK_CON;
         if (con[22]) con[20] = 1'b1;
         steer = rnd() & MASK_STEER;
         ahb(1, ADDR_CON, con);
         ahb(1, ADDR_STEER, steer);
         @(negedge hclk);
         chk(loopback_en, con[21]);
         for (int f = 0; f < 12; f++) begin
            t = rnd();
            d = rnd();
            fr = d[26:0];
            fr.valid = 1'b1;
            fr.tag = (t[1:0] == 2'h0) ? VLAN_INNER : (t[1:0] == 2'h1) ? con[15:0] :
               {(t[2] ? TAG_FIRST : t[15:8]), t[23:16]};
            ed.valid = 1'b1;
            ed.ring = con[22] ? (fr.port > MAX_PORT || !steer[8 + fr.port]) : !steer[fr.prio];
            ed.drop = (fr.addr_unknown & con[19]) | (|(fr.sum_err & con[18:16]));
            ed.sum_report = fr.sum_err & ~con[18:16];
            ed.special_tag = con[20] && fr.tag[15:8] == 8'h81;
            ed.outer_vlan = fr.tag == con[15:0];
            ed.inner_vlan = fr.tag == 16'h8100;
            @(posedge hclk);
            rx_frame <= fr;
            @(posedge hclk);
            rx_frame.valid <= 1'b0;
            @(negedge hclk);
            chk({23'h0, rx_dec}, {23'h0, ed});
         end
      end
      $display("test receive done");
      // free counts just around the threshold
      for (int c = 0; c < 8; c++) begin
         t = rnd();
         ahb(1, ADDR_FREEQ, t);
         ahb(1, ADDR_STEER, t);
         c0 = {8'h0, t[3:0]} + {10'h0, t[5:4]} - 12'h1;
         c1 = {8'h0, t[3:0]} + {10'h0, t[7:6]} - 12'h1;
         sx = {c1 <= {8'h0, t[3:0]}, c0 <= {8'h0, t[3:0]}};
         for (int q = 0; q < 4; q++) pq[q] = t[16 + q] ? sx[0] : sx[1];
         rx_free_cnt0 <= c0;
         rx_free_cnt1 <= c1;
         repeat (3) @(negedge hclk);
         chk(rx_ring_stall, sx);
         chk(switch_queue_pause, pq);
      end
      $display("test ring stall done");
      close_out();
   end
endmodule
`default_nettype wire
